/* common/asrc_pkg.sv */
// constants shared by the serial result readout chain
// assumes a 250 MHz ref_clk and a host that owns the serial clock
//
// What this block does
// [R01] chain select low: gate pin high floats serial output, low drives it
// [R02] with output enabled, top result bit shows as busy falls
// [R03] host keeps gates high, lowers one at a time between conversions
// [R04] lowering gate in normal mode puts the top result bit on the line
// [R05] chain select high: output always driven, gate pin becomes serial input
// [R06] upstream top bit reaches downstream output after eighteen serial clocks
// [R07] downstream samples upstream top bit at first rising serial clock
// [R08] rising convert starts conversion; busy holds; no restart while busy
// [R09] output changes on rising serial clock; host captures falling or next rising
// [R10] top bit stays valid until the first rising serial clock
// [R11] conversion completes and busy drops within 527 ns
// [R12] eighteen bits out top first per rising clock; chain input follows
package asrc_pkg;

  // ****************************************************************
  // result word
  // ****************************************************************
  localparam int unsigned RES_W = 18;
  localparam int unsigned RES_TOP = RES_W - 1;
  localparam logic [RES_W-1:0] RES_RESET = 18'h00000;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned REF_CLK_PERIOD_NS = 4;
  localparam int unsigned CONV_TIME_NS = 527;
  // longest time, so the count rounds down
  localparam int unsigned CONV_CYCLES = CONV_TIME_NS / REF_CLK_PERIOD_NS;
  localparam int unsigned CONV_CNT_W = 8;
  localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);
  localparam logic [CONV_CNT_W-1:0] CONV_CNT_RESET = 8'h00;

  // ****************************************************************
  // pin synchroniser slots
  // ****************************************************************
  localparam int unsigned PIN_N = 3;
  localparam int unsigned PIN_CONVERT = 0;
  localparam int unsigned PIN_GATE = 1;
  localparam int unsigned PIN_CHAIN = 2;
  localparam logic [PIN_N-1:0] PIN_RESET = 3'h2;

  // ****************************************************************
  // conversion state
  // ****************************************************************
  typedef enum logic [0:0] {
    ASRC_IDLE,
    ASRC_CONV
  } asrc_conv_e;

endpackage

/* src/asrc_shift.sv */
// serial clock domain shifter of the readout chain
// assumes the word and its generation toggle stay still while the host clocks
`timescale 1ns/100ps
module asrc_shift (
  input  wire logic                       serial_clk,
  input  wire logic                       reset,
  input  wire logic [asrc_pkg::RES_W-1:0] word_in,
  input  wire logic                       gen_tgl,
  input  wire logic                       read_gate_or_serial_in,
  output logic                            gen_seen_r,
  output logic                            shift_top_r
);
  import asrc_pkg::*;

  logic             rst_meta_r;
  logic             rst_sync_r;
  logic [RES_W-1:0] shreg_r;
  logic [RES_W-1:0] shreg_nxt;
  logic             first_edge;

  // ****************************************************************
  // reset into the serial clock domain
  // ****************************************************************
  always_ff @(posedge serial_clk) begin
    rst_meta_r <= reset;
    rst_sync_r <= rst_meta_r;
  end

  // ****************************************************************
  // shift path
  // ****************************************************************
  // a new generation means this edge is the first of a readout
  assign first_edge = gen_tgl != gen_seen_r;

  always_comb begin
    if (first_edge) begin
      shreg_nxt = {word_in[RES_TOP-1:0], read_gate_or_serial_in}; // [R07]
    end else begin
      shreg_nxt = {shreg_r[RES_TOP-1:0], read_gate_or_serial_in}; // [R12]
    end
  end

  always_ff @(posedge serial_clk) begin
    if (rst_sync_r) begin
      shreg_r <= RES_RESET;
    end else begin
      shreg_r <= shreg_nxt; // [R09]
    end
  end

  always_ff @(posedge serial_clk) begin
    if (rst_sync_r) begin
      gen_seen_r <= 1'b0;
    end else begin
      gen_seen_r <= gen_tgl;
    end
  end

  // after eighteen edges the bit taken on the first edge sits on top
  always_ff @(posedge serial_clk) begin
    if (rst_sync_r) begin
      shift_top_r <= 1'b0;
    end else begin
      shift_top_r <= shreg_nxt[RES_TOP]; // [R06]
    end
  end

endmodule

/* src/asrc_top.sv */
// converter core timing and serial result readout port
// assumes conv_value is settled by the analog core on ref_clk,
// and that the host keeps the serial clock still during a conversion
`timescale 1ns/100ps
module asrc_top (
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  input  wire logic                       serial_clk,
  input  wire logic                       convert_start,
  input  wire logic                       chain_select,
  input  wire logic                       read_gate_or_serial_in,
  input  wire logic [asrc_pkg::RES_W-1:0] conv_value,
  output logic                            busy_r,
  output logic                            serial_result_out,
  output logic                            serial_result_oe
);
  import asrc_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [PIN_N-1:0]      pin_raw;
  logic [PIN_N-1:0]      pin_meta_r;
  logic [PIN_N-1:0]      pin_sync_r;
  logic                  convert_prev_r;
  logic                  convert_rise;
  logic                  gate_s;
  logic                  chain_s;
  asrc_conv_e            state_r;
  asrc_conv_e            state_nxt;
  logic [CONV_CNT_W-1:0] conv_cnt_r;
  logic                  conv_done;
  logic [RES_W-1:0]      result_r;
  logic                  gen_tgl_r;
  logic                  gen_seen;
  logic                  seen_meta_r;
  logic                  seen_sync_r;
  logic                  shift_top;
  logic                  top_meta_r;
  logic                  top_sync_r;
  logic                  fresh;
  logic                  sdo_r;
  logic                  sdo_oe_r;

  // output drive decision, registered as the enable that also masks the data
  function automatic logic asrc_drive(input logic chain, input logic gate);
    asrc_drive = chain | ~gate; // [R01] [R05]
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  assign pin_raw[PIN_CONVERT] = convert_start;
  assign pin_raw[PIN_GATE]    = read_gate_or_serial_in;
  assign pin_raw[PIN_CHAIN]   = chain_select;

  for (genvar gi = 0; gi < PIN_N; gi++) begin : g_pin_sync
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        pin_meta_r[gi] <= PIN_RESET[gi];
        pin_sync_r[gi] <= PIN_RESET[gi];
      end else begin
        pin_meta_r[gi] <= pin_raw[gi];
        pin_sync_r[gi] <= pin_meta_r[gi];
      end
    end
  end

  assign gate_s  = pin_sync_r[PIN_GATE];
  assign chain_s = pin_sync_r[PIN_CHAIN];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      convert_prev_r <= 1'b0;
    end else begin
      convert_prev_r <= pin_sync_r[PIN_CONVERT];
    end
  end

  assign convert_rise = pin_sync_r[PIN_CONVERT] & ~convert_prev_r;

  // ****************************************************************
  // conversion sequencing
  // ****************************************************************
  assign conv_done = (state_r == ASRC_CONV) && (conv_cnt_r == CONV_LAST); // [R11]

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ASRC_IDLE: begin
        if (convert_rise) begin
          state_nxt = ASRC_CONV; // [R08]
        end
      end
      ASRC_CONV: begin
        // further convert edges are ignored until the word is done
        if (conv_done) begin
          state_nxt = ASRC_IDLE; // [R08]
        end
      end
      default: begin
        state_nxt = ASRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= ASRC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      conv_cnt_r <= CONV_CNT_RESET;
    end else if (state_r == ASRC_CONV) begin
      conv_cnt_r <= conv_cnt_r + 8'h01; // [R11]
    end else begin
      conv_cnt_r <= CONV_CNT_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_r <= 1'b0;
    end else if (state_nxt == ASRC_CONV) begin
      busy_r <= 1'b1; // [R08]
    end else begin
      busy_r <= 1'b0; // [R11]
    end
  end

  // ****************************************************************
  // result word and its generation toggle
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result_r <= RES_RESET;
    end else if (conv_done) begin
      result_r <= conv_value;
    end
  end

  // the toggle tells the serial side that the next edge starts a readout
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gen_tgl_r <= 1'b0;
    end else if (conv_done) begin
      gen_tgl_r <= ~gen_tgl_r;
    end
  end

  // ****************************************************************
  // serial clock domain
  // ****************************************************************
  asrc_shift u_shift (
    .serial_clk             (serial_clk),
    .reset                  (reset),
    .word_in                (result_r),
    .gen_tgl                (gen_tgl_r),
    .read_gate_or_serial_in (read_gate_or_serial_in),
    .gen_seen_r             (gen_seen),
    .shift_top_r            (shift_top)
  );

  // ****************************************************************
  // crossings back from the serial clock domain
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      seen_meta_r <= 1'b0;
      seen_sync_r <= 1'b0;
    end else begin
      seen_meta_r <= gen_seen;
      seen_sync_r <= seen_meta_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      top_meta_r <= 1'b0;
      top_sync_r <= 1'b0;
    end else begin
      top_meta_r <= shift_top;
      top_sync_r <= top_meta_r;
    end
  end

  // word not yet touched by any serial clock edge
  assign fresh = gen_tgl_r != seen_sync_r; // [R10]

  // ****************************************************************
  // serial output pin
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sdo_r <= 1'b0;
    end else if (conv_done) begin
      sdo_r <= conv_value[RES_TOP]; // [R02]
    end else if (fresh) begin
      sdo_r <= result_r[RES_TOP]; // [R04] [R10]
    end else begin
      sdo_r <= top_sync_r; // [R09] [R12]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sdo_oe_r <= 1'b0;
    end else begin
      sdo_oe_r <= asrc_drive(chain_s, gate_s); // [R01] [R04] [R05]
    end
  end

  // data stays low while not driven so nothing leaks when the line floats
  assign serial_result_out = sdo_r & sdo_oe_r;
  assign serial_result_oe  = sdo_oe_r;

endmodule

/* bench/asrc_properties.sv */
// checker of the readout port, bound onto asrc_top
// assumes pins are only looked at on ref_clk; serial clock edges are counted on serial_clk itself
`timescale 1ns/100ps
module asrc_properties (
  input wire logic                       ref_clk,
  input wire logic                       reset,
  input wire logic                       serial_clk,
  input wire logic                       convert_start,
  input wire logic                       chain_select,
  input wire logic                       read_gate_or_serial_in,
  input wire logic [asrc_pkg::RES_W-1:0] conv_value,
  input wire logic                       busy_r,
  input wire logic                       serial_result_out,
  input wire logic                       serial_result_oe
);
  import asrc_pkg::*;
  // ****
  // helpers
  // ****
  logic [2:0] up_r;
  logic [7:0] bcnt_r;
  logic [3:0] quiet_r;
  logic       sc_tgl_r;
  logic       sc_seen_r;
  always_ff @(posedge ref_clk) begin
    if (reset)
      up_r <= 3'h0;
    else if (up_r != 3'h7)
      up_r <= up_r + 3'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (reset || !busy_r)
      bcnt_r <= 8'h00;
    else
      bcnt_r <= bcnt_r + 8'h01;
  end
  // short serial pulses can fall between ref edges, so count edges by toggle
  always_ff @(posedge serial_clk) begin
    if (reset)
      sc_tgl_r <= 1'b0;
    else
      sc_tgl_r <= ~sc_tgl_r;
  end
  always_ff @(posedge ref_clk) begin
    sc_seen_r <= sc_tgl_r;
  end
  // ref cycles since a rising serial clock edge was last seen
  always_ff @(posedge ref_clk) begin
    if (reset || (sc_tgl_r != sc_seen_r))
      quiet_r <= 4'h0;
    else if (quiet_r != 4'hF)
      quiet_r <= quiet_r + 4'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_oe_normal: assert property (up_r > 3'h3 && !$past(chain_select, 3)
    |-> serial_result_oe == !$past(read_gate_or_serial_in, 3)) else $error("oe not gated");
  chk_oe_chain: assert property (up_r > 3'h3 && $past(chain_select, 3)
    |-> serial_result_oe) else $error("oe low in chain mode");
  chk_out_floated: assert property (!serial_result_oe |-> !serial_result_out)
    else $error("data while not driving");
  chk_busy_start: assert property ($rose(convert_start) && !busy_r |-> ##[1:4] busy_r)
    else $error("busy did not rise");
  chk_busy_hold: assert property ($rose(busy_r) |=> busy_r [*8])
    else $error("busy dropped early");
  chk_busy_length: assert property ($fell(busy_r) |-> bcnt_r == 8'h83)
    else $error("busy length wrong");
  chk_top_bit_end: assert property ($fell(busy_r) && serial_result_oe
    |-> serial_result_out == $past(conv_value[RES_TOP])) else $error("top bit missing");
  chk_top_bit_holds: assert property (quiet_r > 4'h6 && !$fell(busy_r)
    && $stable(serial_result_oe) |-> $stable(serial_result_out)) else $error("bit moved");
  chk_out_moves: assert property ($changed(serial_result_out) |-> quiet_r < 4'h7
    || $fell(busy_r) || $changed(serial_result_oe)) else $error("change without cause");
endmodule

/* bench/asrc_host_model.sv */
// host model: bursts of serial clock, capture of the data line, upstream device
// assumes the bench calls its tasks one at a time
`timescale 1ns/100ps
module asrc_host_model (
  output logic      serial_clk,
  input  wire logic serial_result_out,
  output logic      up_data
);
  import asrc_pkg::*;
  // ****
  // serial side
  // ****
  logic [RES_W-1:0] up_sr;
  assign up_data = up_sr[RES_TOP];
  // upstream shifts top first on rising clock, then a changing pattern
  always @(posedge serial_clk) up_sr <= {up_sr[RES_W-2:0], ~up_sr[0]};
  // clock still outside bursts; a few edges during reset only
  initial begin
    serial_clk = 1'b0;
    up_sr = 18'h00000;
    repeat (5) begin
      serial_clk = #3.3 1'b1;
      serial_clk = #2.7 1'b0;
    end
  end
  task automatic load_up(input logic [RES_W-1:0] w);
    up_sr = w;
  endtask
  // clocks only between conversions, captures well after each change
  task automatic read_bits(input int n, input int gap, output logic [35:0] got);
    got = 36'h0;
    for (int i = 0; i < n; i++) begin
      serial_clk = #gap 1'b1;
      serial_clk = #3 1'b0;
      // sample late, once the synchronised output has settled
      #17 got = {got[34:0], serial_result_out};
    end
  endtask
endmodule

/* bench/testbench.sv */
// self-checking bench of the readout port with a host model
// assumes asrc_top, asrc_host_model and asrc_properties compiled first
`timescale 1ns/100ps
module testbench;
  import asrc_pkg::*;
  // ****
  // bench
  // ****
  logic             ref_clk, reset, convert_start, chain_select, gate, serial_clk;
  logic [RES_W-1:0] conv_value;
  logic             busy_r, serial_result_out, serial_result_oe, up_data, pin;
  logic [35:0]      got;
  int               error_cnt, num_checks, cyc;
  assign pin = chain_select ? up_data : gate;
  asrc_top i_asrc_top (.ref_clk(ref_clk), .reset(reset), .serial_clk(serial_clk),
    .convert_start(convert_start), .chain_select(chain_select),
    .read_gate_or_serial_in(pin), .conv_value(conv_value), .busy_r(busy_r),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe));
  asrc_host_model i_asrc_host_model (.serial_clk(serial_clk),
    .serial_result_out(serial_result_out), .up_data(up_data));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic convert(input logic [RES_W-1:0] w);
    int n;
    n = 0;
    conv_value = w;
    convert_start = 1'b1;
    for (int i = 0; i < 300; i++) begin
      tick(1);
      convert_start = (i < 20 || i > 22);
      if (busy_r === 1'b1) n++;
      if (n > 0 && busy_r !== 1'b1) break;
    end
    convert_start = 1'b0;
    check(36'(n), 36'(CONV_CYCLES));
    tick(4);
  endtask
  task automatic test_normal(input logic gate_v, input logic [RES_W-1:0] w);
    gate = gate_v;
    tick(4);
    convert(w);
    check(serial_result_oe, !gate_v);
    if (gate_v) begin
      check(serial_result_out, 1'b0);
      gate = 1'b0;
      tick(4);
      check(serial_result_oe, 1'b1);
    end
    check(serial_result_out, w[RES_TOP]);
    i_asrc_host_model.read_bits(18, gate_v ? 13 : 1, got);
    check(got[17:0], {w[16:0], 1'b0});
    gate = 1'b1;
    $display("test_normal done");
  endtask
  task automatic test_chain(input logic [RES_W-1:0] w, input logic [RES_W-1:0] u);
    chain_select = 1'b1;
    i_asrc_host_model.load_up(u);
    tick(4);
    check(serial_result_oe, 1'b1);
    convert(w);
    check(serial_result_out, w[RES_TOP]);
    i_asrc_host_model.read_bits(36, 7, got);
    check(got[35:1], {w[16:0], u});
    chain_select = 1'b0;
    tick(4);
    check(serial_result_oe, 1'b0);
    $display("test_chain done");
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    reset = 1'b1;
    conv_value = 18'h00000;
    convert_start = 1'b0;
    chain_select = 1'b0;
    gate = 1'b1;
    tick(10);
    reset = 1'b0;
    // the serial side leaves reset only on its own clock edges
    i_asrc_host_model.read_bits(3, 2, got);
    tick(2);
    test_normal(1'b1, 18'h2A5C3);
    test_normal(1'b0, 18'h1FFFE);
    test_chain(18'h3C0F1, 18'h2B4D6);
    summarize();
  end
endmodule
bind asrc_top asrc_properties i_asrc_properties (.ref_clk(ref_clk), .reset(reset),
  .serial_clk(serial_clk), .convert_start(convert_start), .chain_select(chain_select),
  .read_gate_or_serial_in(read_gate_or_serial_in), .conv_value(conv_value),
  .busy_r(busy_r), .serial_result_out(serial_result_out),
  .serial_result_oe(serial_result_oe));
